// ### verilog/spw_top.sv
// Functional notes
// - polarity bit inverts channel waveform
// - pin enable routes channel to pin
// - duty register sets high time
// - enable bit gates overflow interrupt
// - priority bit selects high or low
// - run bit starts counter; routed channels drive their count-zero level while stopped
// - counter runs with all pins off
// - one period, one interrupt shared
// - counter wraps after period value
// - overflow flag cleared only by software
// - clock select picks prescale ratio
// - stop clears counter, routing kept
`timescale 1ns/10ps
`default_nettype none
module spw_top (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [5:0]       pwm_pin_out,
    output logic [5:0]       pwm_pin_oe,
    output logic             irq,
    output logic             irq_high_priority
);
    typedef enum logic [1:0] {
        SPW_IDLE = 2'b01,
        SPW_ACC  = 2'b10
    } spw_bus_e;

    spw_bus_e          st;
    spw_bus_e          next_st;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;

    logic              irq_en;
    logic              irq_pri;
    logic [5:0]        cfg0;
    logic              run;
    logic              flag;
    logic [2:0]        en_lo;
    logic [2:0]        cks;
    logic [7:0]        period;
    logic [2:0]        inv_hi;
    logic [7:0]        duty [spw_pkg::SPW_CH];
    logic              next_irq_en;
    logic              next_irq_pri;
    logic [5:0]        next_cfg0;
    logic              next_run;
    logic              next_flag;
    logic [2:0]        next_en_lo;
    logic [2:0]        next_cks;
    logic [7:0]        next_period;
    logic [2:0]        next_inv_hi;
    logic [7:0]        next_duty [spw_pkg::SPW_CH];
    logic              next_irq;

    logic [7:0]        idx;
    logic              acc_wr;
    logic              acc_rd;
    logic [7:0]        wb;
    logic [5:0]        inv;
    logic [5:0]        route_en;
    spw_pkg::spw_cfg_s cfg;
    spw_pkg::spw_cnt_s cnt;

    // duty slot of an index, 7 when the index is no duty register
    function automatic logic [2:0] duty_slot(input logic [7:0] i);
        case (i)
            spw_pkg::SPW_IDX_DUTY0: duty_slot = 3'h0;
            spw_pkg::SPW_IDX_DUTY1: duty_slot = 3'h1;
            spw_pkg::SPW_IDX_DUTY2: duty_slot = 3'h2;
            spw_pkg::SPW_IDX_DUTY3: duty_slot = 3'h3;
            spw_pkg::SPW_IDX_DUTY4: duty_slot = 3'h4;
            spw_pkg::SPW_IDX_DUTY5: duty_slot = 3'h5;
            default:                duty_slot = 3'h7;
        endcase
    endfunction : duty_slot

    assign idx    = paddr[9:2];
    assign wb     = pwdata[7:0];
    assign acc_wr = (st == SPW_ACC) && psel && penable && pwrite && !pslverr;
    assign acc_rd = (st == SPW_ACC) && psel && penable && !pwrite && !pslverr;

    assign inv      = {inv_hi, cfg0[spw_pkg::SPW_CFG_INV_LO +: 3]};
    assign route_en = {cfg0[spw_pkg::SPW_CFG_EN_LO +: 3], en_lo};

    // one counter and period for all
    assign cfg = '{run:    run,
                   cks:    cks,
                   period: period};

    spw_counter u_counter (
        .clk   (clk),
        .reset (reset),
        .cfg   (cfg),
        .cnt   (cnt)
    );

    // bus: setup decodes and prepares the answer, access cycle has pready high
    always_comb begin
        logic [7:0] rd;
        logic       hit;
        rd           = 8'h00;
        hit          = 1'b1;
        next_st      = st;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = pslverr;
        case (idx)
            spw_pkg::SPW_IDX_IRQ_EN:  rd[spw_pkg::SPW_IRQ_BIT] = irq_en;
            spw_pkg::SPW_IDX_IRQ_PRI: rd[spw_pkg::SPW_IRQ_BIT] = irq_pri;
            spw_pkg::SPW_IDX_CFG0:    rd[5:0] = cfg0;
            spw_pkg::SPW_IDX_CTRL:    rd = {run, flag, en_lo, cks};
            spw_pkg::SPW_IDX_PERIOD:  rd = period;
            spw_pkg::SPW_IDX_CFG1:    rd[spw_pkg::SPW_CFG_INV_LO +: 3] = inv_hi;
            spw_pkg::SPW_IDX_STATUS:  rd[spw_pkg::SPW_STAT_OVF] = flag;
            default: begin
                if (duty_slot(idx) != 3'h7) begin
                    rd = duty[duty_slot(idx)];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
        case (st)
            SPW_IDLE: begin
                if (psel && !penable) begin
                    next_st      = SPW_ACC;
                    next_pready  = 1'b1;
                    next_pslverr = !hit || (paddr[11:10] != 2'b00);
                    next_prdata  = {24'h000000, rd};
                end
            end
            SPW_ACC: begin
                next_st      = SPW_IDLE;
                next_pslverr = 1'b0;
            end
            default: next_st = SPW_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st      <= SPW_IDLE;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            st      <= next_st;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // register file; writes land at the edge where pready is sampled high
    always_comb begin
        next_irq_en  = irq_en;
        next_irq_pri = irq_pri;
        next_cfg0    = cfg0;
        next_run     = run;
        next_flag    = flag;
        next_en_lo   = en_lo;
        next_cks     = cks;
        next_period  = period;
        next_inv_hi  = inv_hi;
        next_duty    = duty;
        if (acc_wr) begin
            case (idx)
                spw_pkg::SPW_IDX_IRQ_EN:  next_irq_en = wb[spw_pkg::SPW_IRQ_BIT];
                spw_pkg::SPW_IDX_IRQ_PRI: next_irq_pri = wb[spw_pkg::SPW_IRQ_BIT];
                spw_pkg::SPW_IDX_CFG0:    next_cfg0 = wb[5:0];
                spw_pkg::SPW_IDX_CTRL: begin
                    next_run   = wb[spw_pkg::SPW_CTRL_RUN];
                    next_en_lo = wb[spw_pkg::SPW_CTRL_EN_LO +: 3];
                    next_cks   = wb[spw_pkg::SPW_CTRL_CKS_LO +: 3];
                    if (!wb[spw_pkg::SPW_CTRL_FLAG]) begin
                        next_flag = 1'b0;
                    end
                end
                // period change takes effect at once
                spw_pkg::SPW_IDX_PERIOD:  next_period = wb;
                spw_pkg::SPW_IDX_CFG1:    next_inv_hi = wb[spw_pkg::SPW_CFG_INV_LO +: 3];
                default: begin
                    if (duty_slot(idx) != 3'h7) begin
                        next_duty[duty_slot(idx)] = wb;
                    end
                end
            endcase
        end
        // only a flag that the read returned is cleared, so no event is lost
        if (acc_rd && idx == spw_pkg::SPW_IDX_STATUS && prdata[spw_pkg::SPW_STAT_OVF]) begin
            next_flag = 1'b0;
        end
        // overflow flags even with pins off
        if (cnt.overflow) begin
            next_flag = 1'b1;
        end
        next_irq = next_flag && next_irq_en;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_en  <= 1'b0;
            irq_pri <= 1'b0;
            cfg0    <= 6'h00;
            run     <= 1'b0;
            flag    <= 1'b0;
            en_lo   <= 3'h0;
            cks     <= 3'h0;
            period  <= spw_pkg::SPW_RST_BYTE;
            inv_hi  <= 3'h0;
            for (int i = 0; i < spw_pkg::SPW_CH; i++) begin
                duty[i] <= spw_pkg::SPW_RST_BYTE;
            end
            irq               <= 1'b0;
            irq_high_priority <= 1'b0;
        end else begin
            irq_en  <= next_irq_en;
            irq_pri <= next_irq_pri;
            cfg0    <= next_cfg0;
            run     <= next_run;
            flag    <= next_flag;
            en_lo   <= next_en_lo;
            cks     <= next_cks;
            period  <= next_period;
            inv_hi  <= next_inv_hi;
            duty    <= next_duty;
            irq     <= next_irq;
            irq_high_priority <= next_irq_pri;
        end
    end

    // channel outputs; disabled pins drive low with enable off
    genvar ch;
    generate
        for (ch = 0; ch < spw_pkg::SPW_CH; ch++) begin : g_ch
            logic next_out;
            logic next_oe;
            always_comb begin
                // high below duty, zero duty low
                next_out = ((cnt.count < duty[ch]) ^ inv[ch]) && route_en[ch];
                next_oe  = route_en[ch];
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    pwm_pin_out[ch] <= 1'b0;
                    pwm_pin_oe[ch]  <= 1'b0;
                end else begin
                    pwm_pin_out[ch] <= next_out;
                    pwm_pin_oe[ch]  <= next_oe;
                end
            end
        end
    endgenerate

    property p_duty_high;
        @(posedge clk) disable iff (reset)
        (route_en[0] && !inv[0]) |=> (pwm_pin_out[0] == ($past(cnt.count) < $past(duty[0])));
    endproperty
    a_duty_high: assert property (p_duty_high) else $error("channel 0 level wrong for count");

    property p_invert;
        @(posedge clk) disable iff (reset)
        (route_en[1] && inv[1] && cnt.count < duty[1]) |=> !pwm_pin_out[1];
    endproperty
    a_invert: assert property (p_invert) else $error("inverted channel 1 high inside duty");

    property p_route;
        @(posedge clk) disable iff (reset)
        !route_en[3] |=> (!pwm_pin_oe[3] && !pwm_pin_out[3]);
    endproperty
    a_route: assert property (p_route) else $error("disabled channel 3 drives its pin");

    property p_irq;
        @(posedge clk) disable iff (reset)
        (cnt.overflow && irq_en && !acc_wr) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("overflow with enable gave no interrupt");

    property p_flag_hold;
        @(posedge clk) disable iff (reset)
        (flag && !acc_wr && !acc_rd) |=> flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("overflow flag dropped without software");

    c_irq:    cover property (@(posedge clk) disable iff (reset) irq && route_en == 6'h00);
    c_clear:  cover property (@(posedge clk) disable iff (reset) flag ##1 !flag);
    c_pwm_hi: cover property (@(posedge clk) disable iff (reset) pwm_pin_out[0] ##1 !pwm_pin_out[0]);
endmodule : spw_top
`default_nettype wire

// ### include/spw_pkg.sv
`default_nettype none
package spw_pkg;
    localparam int unsigned SPW_CH = 6;

    // register indexes; byte address is four times the index
    localparam logic [7:0] SPW_IDX_IRQ_EN  = 8'ha9;
    localparam logic [7:0] SPW_IDX_IRQ_PRI = 8'hb9;
    localparam logic [7:0] SPW_IDX_CFG0    = 8'hd1;
    localparam logic [7:0] SPW_IDX_CTRL    = 8'hd2;
    localparam logic [7:0] SPW_IDX_PERIOD  = 8'hd3;
    localparam logic [7:0] SPW_IDX_CFG1    = 8'hd4;
    localparam logic [7:0] SPW_IDX_DUTY0   = 8'hd5;
    localparam logic [7:0] SPW_IDX_DUTY1   = 8'hd6;
    localparam logic [7:0] SPW_IDX_DUTY2   = 8'hd7;
    localparam logic [7:0] SPW_IDX_DUTY3   = 8'hdd;
    localparam logic [7:0] SPW_IDX_DUTY4   = 8'hde;
    localparam logic [7:0] SPW_IDX_DUTY5   = 8'hdf;
    localparam logic [7:0] SPW_IDX_STATUS  = 8'he0;

    // field positions
    localparam int unsigned SPW_IRQ_BIT     = 1;
    localparam int unsigned SPW_CTRL_RUN    = 7;
    localparam int unsigned SPW_CTRL_FLAG   = 6;
    localparam int unsigned SPW_CTRL_EN_LO  = 3;
    localparam int unsigned SPW_CTRL_CKS_LO = 0;
    localparam int unsigned SPW_CFG_INV_LO  = 3;
    localparam int unsigned SPW_CFG_EN_LO   = 0;
    localparam int unsigned SPW_STAT_OVF    = 0;

    localparam logic [7:0] SPW_RST_BYTE = 8'h00;
    localparam logic [7:0] SPW_RST_CNT  = 8'h00;

    typedef struct packed {
        logic       run;
        logic [2:0] cks;
        logic [7:0] period;
    } spw_cfg_s;

    typedef struct packed {
        logic [7:0] count;
        logic       overflow;
    } spw_cnt_s;

    // terminal count of the prescaler for each clock select code
    function automatic logic [7:0] spw_div_last(input logic [2:0] cks);
        case (cks)
            3'h0:    spw_div_last = 8'h00;
            3'h1:    spw_div_last = 8'h01;
            3'h2:    spw_div_last = 8'h03;
            3'h3:    spw_div_last = 8'h07;
            3'h4:    spw_div_last = 8'h1f;
            3'h5:    spw_div_last = 8'h3f;
            3'h6:    spw_div_last = 8'h7f;
            default: spw_div_last = 8'hff;
        endcase
    endfunction : spw_div_last
endpackage : spw_pkg
`default_nettype wire

// ### verilog/spw_counter.sv
`timescale 1ns/10ps
`default_nettype none
module spw_counter (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire spw_pkg::spw_cfg_s cfg,
    output spw_pkg::spw_cnt_s      cnt
);
    logic [7:0] div;
    logic [7:0] count;
    logic       ovf;
    logic [7:0] next_div;
    logic [7:0] next_count;
    logic       next_ovf;
    logic       tick;

    always_comb begin
        next_div   = div;
        next_count = count;
        next_ovf   = 1'b0;
        // >= so that a smaller select code or period takes effect at once
        tick       = div >= spw_pkg::spw_div_last(cfg.cks);
        if (!cfg.run) begin
            next_div   = spw_pkg::SPW_RST_CNT;
            next_count = spw_pkg::SPW_RST_CNT;
        end else if (tick) begin
            next_div = spw_pkg::SPW_RST_CNT;
            if (count >= cfg.period) begin
                next_count = spw_pkg::SPW_RST_CNT;
                next_ovf   = 1'b1;
            end else begin
                next_count = count + 8'h01;
            end
        end else begin
            next_div = div + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div   <= spw_pkg::SPW_RST_CNT;
            count <= spw_pkg::SPW_RST_CNT;
            ovf   <= 1'b0;
        end else begin
            div   <= next_div;
            count <= next_count;
            ovf   <= next_ovf;
        end
    end

    // one driver for the whole carrier
    assign cnt = {count, ovf};

    property p_wrap;
        @(posedge clk) disable iff (reset)
        (cfg.run && tick && count == cfg.period) |=> (ovf && count == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap at period");

    property p_stop;
        @(posedge clk) disable iff (reset)
        !cfg.run |=> (count == 8'h00 && !ovf);
    endproperty
    a_stop: assert property (p_stop) else $error("counter not cleared while stopped");

    property p_prescale;
        @(posedge clk) disable iff (reset)
        (cfg.run && !tick) |=> (count == $past(count) && !ovf);
    endproperty
    a_prescale: assert property (p_prescale) else $error("counter moved without prescaler tick");

    c_overflow: cover property (@(posedge clk) disable iff (reset) ovf);
endmodule : spw_counter
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [7:0] IEN = spw_pkg::SPW_IDX_IRQ_EN;
    localparam logic [7:0] IPR = spw_pkg::SPW_IDX_IRQ_PRI;
    localparam logic [7:0] CF0 = spw_pkg::SPW_IDX_CFG0;
    localparam logic [7:0] CTL = spw_pkg::SPW_IDX_CTRL;
    localparam logic [7:0] PRD = spw_pkg::SPW_IDX_PERIOD;
    localparam logic [7:0] CF1 = spw_pkg::SPW_IDX_CFG1;
    localparam logic [7:0] STA = spw_pkg::SPW_IDX_STATUS;

    logic        clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  pwm_pin_out;
    logic [5:0]  pwm_pin_oe;
    logic        irq;
    logic        irq_high_priority;
    int          err_count;
    int          checks_done;
    logic [31:0] rd;
    logic        er;
    int          hi;
    int          lo;
    int          ones [6];
    // duties 0,1,3,5,9,10 over 4 periods of 10, ch1 and ch4 flipped
    int          exp_ones [6] = '{0, 36, 12, 20, 4, 40};
    logic [7:0]  duty_val [6] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h09, 8'h0a};
    int          ratio [8] = '{1, 2, 4, 8, 32, 64, 128, 256};
    logic [7:0]  reg_idx [13] = '{IEN, IPR, CF0, CTL, PRD, CF1,
                                  spw_pkg::SPW_IDX_DUTY0, spw_pkg::SPW_IDX_DUTY1, spw_pkg::SPW_IDX_DUTY2,
                                  spw_pkg::SPW_IDX_DUTY3, spw_pkg::SPW_IDX_DUTY4, spw_pkg::SPW_IDX_DUTY5, STA};

    spw_top i_dut (
        .clk               (clk),
        .reset             (reset),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .pwm_pin_out       (pwm_pin_out),
        .pwm_pin_oe        (pwm_pin_oe),
        .irq               (irq),
        .irq_high_priority (irq_high_priority)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic final_report;
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ad

    // one transfer; starts after a rising edge so release and next setup never share a step
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wrr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, ad(idx), d);
    endtask : wrr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, ad(idx), 8'h00);
        chk(rd, {24'h000000, exp});
    endtask : rdc

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_irq

    // high and low run lengths of one channel, sampled mid-cycle
    task automatic measure(input int ch);
        int n;
        n = 0;
        @(negedge clk);
        while (pwm_pin_out[ch] === 1'b1 && n < 3000) begin @(negedge clk); n++; end
        while (pwm_pin_out[ch] !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
        hi = 0;
        while (pwm_pin_out[ch] === 1'b1 && hi < 3000) begin @(negedge clk); hi++; end
        lo = 0;
        while (pwm_pin_out[ch] !== 1'b1 && lo < 3000) begin @(negedge clk); lo++; end
    endtask : measure

    initial begin
        repeat (30000) @(posedge clk);
        chk(32'h0, 32'h1);
        final_report();
    end

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        err_count = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk({pwm_pin_out, pwm_pin_oe, irq, irq_high_priority}, 32'h0);
        foreach (reg_idx[i]) rdc(reg_idx[i], 8'h00);
        apb(1'b0, ad(8'h00), 8'h00);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h400 | ad(reg_idx[6]), 8'hff);
        chk(er, 1'b1);
        rdc(reg_idx[6], 8'h00);
        wrr(PRD, 8'h09);
        foreach (duty_val[i]) wrr(reg_idx[6 + i], duty_val[i]);
        foreach (duty_val[i]) rdc(reg_idx[6 + i], duty_val[i]);
        wrr(CF0, 8'h17);
        wrr(CF1, 8'h10);
        rdc(CF0, 8'h17);
        rdc(CF1, 8'h10);
        wrr(CTL, 8'hb8);
        foreach (ones[i]) ones[i] = 0;
        // skip the cycle that still shows the old routing and the stopped count
        @(negedge clk);
        repeat (40) begin
            @(negedge clk);
            for (int c = 0; c < 6; c++) ones[c] += int'(pwm_pin_out[c]);
        end
        foreach (ones[i]) chk(ones[i], exp_ones[i]);
        chk(pwm_pin_oe, 6'h3f);
        wrr(IEN, 8'h02);
        wait_irq();
        chk(irq, 1'b1);
        wrr(IEN, 8'h00);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        // stop keeps flag and routing; counter held at zero
        wrr(CTL, 8'h78);
        wrr(IEN, 8'h02);
        repeat (20) @(negedge clk);
        chk(irq, 1'b1);
        rdc(CTL, 8'h78);
        chk(pwm_pin_out, 6'h2c);
        chk(pwm_pin_oe, 6'h3f);
        rdc(STA, 8'h01);
        rdc(STA, 8'h00);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        wrr(IPR, 8'h02);
        rdc(IPR, 8'h02);
        chk(irq_high_priority, 1'b1);
        wrr(IPR, 8'h00);
        @(negedge clk);
        chk(irq_high_priority, 1'b0);
        wrr(CF0, 8'h10);
        wrr(CTL, 8'h80);
        repeat (2) @(negedge clk);
        chk({pwm_pin_oe, pwm_pin_out}, 12'h000);
        wait_irq();
        chk(irq, 1'b1);
        wrr(IEN, 8'h00);
        apb(1'b0, ad(STA), 8'h00);
        // every prescale code, short period to keep the run brief
        wrr(CTL, 8'h38);
        wrr(CF0, 8'h00);
        wrr(PRD, 8'h02);
        // channel 0 needs a nonzero duty to show a high run
        wrr(spw_pkg::SPW_IDX_DUTY0, 8'h01);
        for (int c = 0; c < 8; c++) begin
            wrr(CTL, {5'b00111, 3'(c)});
            wrr(CTL, {5'b10111, 3'(c)});
            measure(0);
            chk(hi, ratio[c]);
            chk(lo, 2 * ratio[c]);
        end
        final_report();
    end
endmodule : tb
`default_nettype wire
